/* File: verilog/sfm_regs.vh */
// Constants for the servo fault monitor
`ifndef SFM_REGS_VH
`define SFM_REGS_VH
// ----------------------------------------
// Fault codes
// ----------------------------------------
`define SFM_CODE_W 8
`define SFM_CODE_NONE 8'h00
`define SFM_CODE_ENC 8'h69
`define SFM_CODE_NVM 8'h6A
`define SFM_CODE_PHASE 8'h6B
`define SFM_CODE_COMM 8'h6C
`define SFM_CODE_CURR 8'h6D
`define SFM_CODE_WIND 8'h6F
`define SFM_CODE_NOIDX 8'h71
`define SFM_CODE_IDXOFS 8'h72
`define SFM_CODE_HALL 8'h73
`define SFM_CODE_HOT 8'h75
`define SFM_CODE_PWRHALL 8'h76
`define SFM_CODE_TYPE 8'h77
// ----------------------------------------
// Fault bit positions
// ----------------------------------------
`define SFM_NFLT 12
`define SFM_B_ENC 0
`define SFM_B_NVM 1
`define SFM_B_PHASE 2
`define SFM_B_COMM 3
`define SFM_B_CURR 4
`define SFM_B_WIND 5
`define SFM_B_NOIDX 6
`define SFM_B_IDXOFS 7
`define SFM_B_HALL 8
`define SFM_B_HOT 9
`define SFM_B_PWRHALL 10
`define SFM_B_TYPE 11
// ----------------------------------------
// Mask bits, widths and encoder timeout
// ----------------------------------------
`define SFM_MASK_PHASE 2
`define SFM_MASK_CURR 3
`define SFM_MASK_W 16
`define SFM_CUR_W 16
`define SFM_PH_W 16
`define SFM_POS_W 24
`define SFM_TMP_W 12
`define SFM_TYP_W 4
`define SFM_DAT_W 16
`define SFM_ENC_TO_CYC 16'h04E2
`endif

/* File: verilog/sfm_sync.v */
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module sfm_sync #(
	parameter W = 1
) (
	input wire i_sys_clk,
	input wire i_rst_n,
	input wire [W-1:0] i_d,
	output wire [W-1:0] o_q
);
	reg [W-1:0] s1_q;
	reg [W-1:0] s2_q;
	always @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			s1_q <= {W{1'b0}};
			s2_q <= {W{1'b0}};
		end else begin
			s1_q <= i_d;
			s2_q <= s1_q;
		end
	end
	assign o_q = s2_q;
endmodule // sfm_sync
`default_nettype wire

/* File: verilog/sfm_monitor.v */
// Servo drive fault monitor
// Behaviour
// (R1) Encoder silent or unstable raises Er.105
// (R2) Parameter memory read error raises Er.106
// (R3) Hall versus encoder phase mismatch raises Er.107
// (R4) Mask bit 2 suppresses phase fault
// (R5) Host write readback mismatch raises Er.108
// (R6) Successive current samples differ 50% raise Er.109
// (R7) Mask bit 3 suppresses current fault
// (R8) Winding learning wrong current direction raises Er.111
// (R9) Encoder learning without index pulse raises Er.113
// (R10) Index position beyond resolution raises Er.114
// (R11) Hall lines all equal while learning raise Er.115
// (R12) Temperature above threshold raises Er.117
// (R13) Invalid power-up Hall code in reduced-wire mode raises Er.118
// (R14) Detected encoder type mismatch raises Er.119
// (R15) Faults latch until cleared; masked events never latch
`timescale 1ns/1ps
`default_nettype none
`include "sfm_regs.vh"
module sfm_monitor (
	input wire i_sys_clk,
	input wire i_rst_n,
	input wire i_enc_a,
	input wire i_enc_b,
	input wire i_enc_z,
	input wire [2:0] i_hall,
	input wire i_enc_unstable,
	input wire [`SFM_POS_W-1:0] i_enc_pos,
	input wire [`SFM_POS_W-1:0] i_enc_resolution,
	input wire [`SFM_PH_W-1:0] i_hall_phase,
	input wire [`SFM_PH_W-1:0] i_enc_phase,
	input wire [`SFM_PH_W-1:0] i_phase_limit,
	input wire i_nvm_rd_valid,
	input wire i_nvm_rd_err,
	input wire i_host_wr,
	input wire [`SFM_DAT_W-1:0] i_host_wr_data,
	input wire i_host_rb,
	input wire [`SFM_DAT_W-1:0] i_host_rb_data,
	input wire i_cur_valid,
	input wire [`SFM_CUR_W-1:0] i_cur_sample,
	input wire i_wind_learn,
	input wire i_cur_expect_up,
	input wire i_enc_learn,
	input wire i_enc_learn_done,
	input wire [`SFM_TMP_W-1:0] i_drive_temperature_reading,
	input wire [`SFM_TMP_W-1:0] i_overheat_threshold,
	input wire i_power_up_check,
	input wire i_reduced_wire,
	input wire [`SFM_TYP_W-1:0] i_detected_enc_type,
	input wire [`SFM_TYP_W-1:0] i_encoder_type_setting,
	input wire [`SFM_MASK_W-1:0] i_fault_mask_param,
	input wire i_fault_clear,
	output reg [`SFM_NFLT-1:0] o_fault_flags,
	output reg [`SFM_CODE_W-1:0] o_fault_code,
	output reg o_fault_any
);
	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	wire [5:0] pins_s;
	sfm_sync #(.W(6)) u_sync (
		.i_sys_clk(i_sys_clk),
		.i_rst_n(i_rst_n),
		.i_d({i_enc_a, i_enc_b, i_enc_z, i_hall}),
		.o_q(pins_s)
	);
	wire [2:0] hall_s = pins_s[2:0];
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function [`SFM_PH_W-1:0] absdiff;
		input [`SFM_PH_W-1:0] a;
		input [`SFM_PH_W-1:0] b;
		begin
			absdiff = (a > b) ? (a - b) : (b - a);
		end
	endfunction
	function hall_bad;
		input [2:0] h;
		begin
			hall_bad = (h == 3'h0) || (h == 3'h7);
		end
	endfunction
	// ----------------------------------------
	// Event state
	// ----------------------------------------
	reg [1:0] ab_prev_q;
	reg [1:0] warm_q;
	reg [15:0] enc_idle_q;
	reg [`SFM_DAT_W-1:0] wr_val_q;
	reg wr_pend_q;
	reg [`SFM_CUR_W-1:0] cur_prev_q;
	reg cur_have_q;
	reg z_seen_q;
	reg [`SFM_NFLT-1:0] ev;
	reg [`SFM_CUR_W:0] hi_mag;
	reg [`SFM_CUR_W:0] lo_mag;
	reg [`SFM_CODE_W-1:0] code_d;
	reg [`SFM_NFLT-1:0] flags_d;
	integer k;
	wire enc_edge = (pins_s[5:4] != ab_prev_q);
	wire pins_ok = warm_q[1];
	wire enc_to = (enc_idle_q == `SFM_ENC_TO_CYC);
	always @* begin
		ev = {`SFM_NFLT{1'b0}};
		hi_mag = (i_cur_sample > cur_prev_q) ? {1'b0, i_cur_sample} : {1'b0, cur_prev_q};
		lo_mag = (i_cur_sample > cur_prev_q) ? {1'b0, cur_prev_q} : {1'b0, i_cur_sample};
		ev[`SFM_B_ENC] = enc_to || i_enc_unstable; // [R1]
		ev[`SFM_B_NVM] = i_nvm_rd_valid && i_nvm_rd_err; // [R2]
		ev[`SFM_B_PHASE] = (absdiff(i_hall_phase, i_enc_phase) > i_phase_limit); // [R3]
		ev[`SFM_B_COMM] = i_host_rb && wr_pend_q && (i_host_rb_data != wr_val_q); // [R5]
		ev[`SFM_B_CURR] = i_cur_valid && cur_have_q && (hi_mag != 17'h00000)
			&& (((hi_mag - lo_mag) << 1) >= hi_mag); // [R6]
		ev[`SFM_B_WIND] = i_wind_learn && i_cur_valid && cur_have_q
			&& (i_cur_expect_up ? (i_cur_sample < cur_prev_q)
				: (i_cur_sample > cur_prev_q)); // [R8]
		ev[`SFM_B_NOIDX] = i_enc_learn_done && !z_seen_q && !pins_s[3]; // [R9]
		ev[`SFM_B_IDXOFS] = i_enc_learn && pins_s[3] && (i_enc_pos > i_enc_resolution); // [R10]
		ev[`SFM_B_HALL] = i_enc_learn && pins_ok && hall_bad(hall_s); // [R11]
		ev[`SFM_B_HOT] = (i_drive_temperature_reading > i_overheat_threshold); // [R12]
		ev[`SFM_B_PWRHALL] = i_power_up_check && i_reduced_wire
			&& pins_ok && hall_bad(hall_s); // [R13]
		ev[`SFM_B_TYPE] = (i_detected_enc_type != i_encoder_type_setting); // [R14]
		ev[`SFM_B_PHASE] = ev[`SFM_B_PHASE] && !i_fault_mask_param[`SFM_MASK_PHASE]; // [R4]
		ev[`SFM_B_CURR] = ev[`SFM_B_CURR] && !i_fault_mask_param[`SFM_MASK_CURR]; // [R7]
	end
	// ----------------------------------------
	// Latched flags and reported code
	// ----------------------------------------
	always @* begin
		flags_d = (i_fault_clear ? {`SFM_NFLT{1'b0}} : o_fault_flags) | ev; // [R15]
		code_d = `SFM_CODE_NONE;
		for (k = `SFM_NFLT - 1; k >= 0; k = k - 1) begin
			if (flags_d[k]) begin
				case (k)
				`SFM_B_ENC: code_d = `SFM_CODE_ENC;
				`SFM_B_NVM: code_d = `SFM_CODE_NVM;
				`SFM_B_PHASE: code_d = `SFM_CODE_PHASE;
				`SFM_B_COMM: code_d = `SFM_CODE_COMM;
				`SFM_B_CURR: code_d = `SFM_CODE_CURR;
				`SFM_B_WIND: code_d = `SFM_CODE_WIND;
				`SFM_B_NOIDX: code_d = `SFM_CODE_NOIDX;
				`SFM_B_IDXOFS: code_d = `SFM_CODE_IDXOFS;
				`SFM_B_HALL: code_d = `SFM_CODE_HALL;
				`SFM_B_HOT: code_d = `SFM_CODE_HOT;
				`SFM_B_PWRHALL: code_d = `SFM_CODE_PWRHALL;
				default: code_d = `SFM_CODE_TYPE;
				endcase
			end
		end
	end
	// ----------------------------------------
	// Synchroniser warm-up
	// ----------------------------------------
	// Reset level 000 of the Hall sync is an invalid code; ignore it
	always @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			warm_q <= 2'h0;
		end else if (!warm_q[1]) begin
			warm_q <= warm_q + 2'h1; // [R11] [R13]
		end
	end
	// ----------------------------------------
	// Encoder activity watch
	// ----------------------------------------
	always @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ab_prev_q <= 2'h0;
			enc_idle_q <= 16'h0000;
		end else begin
			ab_prev_q <= pins_s[5:4];
			if (enc_edge || enc_to) begin
				enc_idle_q <= 16'h0000;
			end else begin
				enc_idle_q <= enc_idle_q + 16'h0001; // [R1]
			end
		end
	end
	// ----------------------------------------
	// Host write tracking
	// ----------------------------------------
	always @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			wr_val_q <= {`SFM_DAT_W{1'b0}};
			wr_pend_q <= 1'b0;
		end else begin
			if (i_host_wr) begin
				wr_val_q <= i_host_wr_data; // [R5]
				wr_pend_q <= 1'b1;
			end else if (i_host_rb) begin
				wr_pend_q <= 1'b0;
			end
		end
	end
	// ----------------------------------------
	// Current sample history
	// ----------------------------------------
	always @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cur_prev_q <= {`SFM_CUR_W{1'b0}};
			cur_have_q <= 1'b0;
		end else if (i_cur_valid) begin
			cur_prev_q <= i_cur_sample; // [R6] [R8]
			cur_have_q <= 1'b1;
		end
	end
	// ----------------------------------------
	// Index pulse tracking
	// ----------------------------------------
	always @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			z_seen_q <= 1'b0;
		end else begin
			if (!i_enc_learn) begin
				z_seen_q <= 1'b0;
			end else if (pins_s[3]) begin
				z_seen_q <= 1'b1; // [R9]
			end
		end
	end
	// ----------------------------------------
	// Fault registers
	// ----------------------------------------
	always @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_fault_flags <= {`SFM_NFLT{1'b0}};
			o_fault_code <= `SFM_CODE_NONE;
			o_fault_any <= 1'b0;
		end else begin
			o_fault_flags <= flags_d; // [R15]
			o_fault_code <= code_d;
			o_fault_any <= |flags_d;
		end
	end
endmodule // sfm_monitor
`default_nettype wire

/* File: tb/sfm_checker.sv */
// Assertion checker for the servo fault monitor
`timescale 1ns/1ps
`default_nettype none
module sfm_checker (
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	input wire logic i_nvm_rd_valid,
	input wire logic i_nvm_rd_err,
	input wire logic [11:0] i_drive_temperature_reading,
	input wire logic [11:0] i_overheat_threshold,
	input wire logic [3:0] i_detected_enc_type,
	input wire logic [3:0] i_encoder_type_setting,
	input wire logic [15:0] i_fault_mask_param,
	input wire logic i_fault_clear,
	input wire logic [11:0] o_fault_flags,
	input wire logic [7:0] o_fault_code,
	input wire logic o_fault_any
);
	wire hot_w = i_drive_temperature_reading > i_overheat_threshold;
	wire type_w = i_detected_enc_type != i_encoder_type_setting;
	wire nvm_w = i_nvm_rd_valid && i_nvm_rd_err;
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_rst_n);
	a_hot_flag:
		assert property (hot_w |=> o_fault_flags[9]) else $error("no hot flag");
	a_type_flag:
		assert property (type_w |=> o_fault_flags[11]) else $error("no type flag");
	a_nvm_flag:
		assert property (nvm_w |=> o_fault_flags[1]) else $error("no nvm flag");
	a_phase_mask:
		assert property ($rose(o_fault_flags[2]) |-> !$past(i_fault_mask_param[2])) else $error("phase");
	a_curr_mask:
		assert property ($rose(o_fault_flags[4]) |-> !$past(i_fault_mask_param[3])) else $error("curr");
	a_flag_sticky:
		assert property (!i_fault_clear |=> (o_fault_flags & $past(o_fault_flags))
			== $past(o_fault_flags)) else $error("flag lost");
	a_any_flags:
		assert property (o_fault_any == (|o_fault_flags)) else $error("any wrong");
	a_code_none:
		assert property (o_fault_flags == 12'h000 |-> o_fault_code == 8'h00) else $error("code");
	a_code_enc:
		assert property (o_fault_flags[0] |-> o_fault_code == 8'h69) else $error("enc code");
	cover property ($rose(o_fault_flags[9]));
	cover property ($rose(o_fault_flags[4]));
	cover property (i_fault_clear && o_fault_any);
endmodule // sfm_checker
`default_nettype wire

/* File: tb/sfm_enc_model.sv */
// Encoder with Hall lines seen by the fault monitor
`timescale 1ns/1ps
`default_nettype none
module sfm_enc_model (
	input wire logic i_clk,
	input wire logic i_run,
	input wire logic i_bad_hall,
	output logic o_a,
	output logic o_b,
	output logic o_z,
	output logic [2:0] o_hall
);
	logic [5:0] pos_q = 6'h00;
	always @(posedge i_clk) begin
		if (i_run)
			pos_q <= pos_q + 6'h01;
	end
	// Gray-coded quadrature, lines stand still when stopped
	assign o_a = pos_q[3];
	assign o_b = pos_q[3] ^ pos_q[2];
	assign o_z = i_run && pos_q == 6'h00;
	assign o_hall = i_bad_hall ? {3{pos_q[5]}} : {1'b0, pos_q[4], 1'b1};
endmodule // sfm_enc_model
`default_nettype wire

/* File: tb/tb.sv */
// Self-checking bench for the servo fault monitor
`timescale 1ns/1ps
`default_nettype none
`define CHK(n,e,a) begin n_tests++; if ((a) !== (e)) begin bad_count++; $display("[ERR] %s exp %h got %h", n, e, a); end end
module tb;
	logic i_sys_clk=0, i_rst_n=0, i_enc_unstable=0, i_nvm_rd_valid=0, i_nvm_rd_err=0, i_host_wr=0;
	logic i_host_rb=0, i_cur_valid=0, i_wind_learn=0, i_cur_expect_up=1, i_enc_learn=0;
	logic i_enc_learn_done=0, i_power_up_check=0, i_reduced_wire=0, i_fault_clear=0, run=1, bad=0;
	logic i_enc_a, i_enc_b, i_enc_z, o_fault_any;
	logic [2:0] i_hall;
	logic [23:0] i_enc_pos=0, i_enc_resolution=24'h000FA0;
	logic [15:0] i_hall_phase=0, i_enc_phase=0, i_phase_limit=16'h0100, i_host_wr_data=0;
	logic [15:0] i_host_rb_data=0, i_cur_sample=0, i_fault_mask_param=0;
	logic [11:0] i_drive_temperature_reading=0, i_overheat_threshold=12'h320, o_fault_flags;
	logic [3:0] i_detected_enc_type=0, i_encoder_type_setting=0;
	logic [7:0] o_fault_code, ex;
	logic [23:0] rows [4] = '{24'h321075, 24'h320000, 24'h000377, 24'hFFFF75};
	int bad_count=0, n_tests=0;
	sfm_monitor dut_u (.*);
	sfm_enc_model enc_u (.i_clk(i_sys_clk), .i_run(run), .i_bad_hall(bad), .o_a(i_enc_a),
		.o_b(i_enc_b), .o_z(i_enc_z), .o_hall(i_hall));
	initial forever #4 i_sys_clk = ~i_sys_clk;
	task automatic step(input int n);
		repeat (n) @(negedge i_sys_clk);
	endtask
	task automatic clr;
		i_fault_clear = 1;
		step(1);
		i_fault_clear = 0;
		step(1);
		`CHK("clear", 12'h000, o_fault_flags)
		$display("test ends, %0d checks so far", n_tests);
	endtask
	task automatic cur(input logic [15:0] v);
		{i_cur_valid, i_cur_sample} = {1'b1, v};
		step(1);
		i_cur_valid = 0;
		step(1);
	endtask
	task automatic test_done;
		$display("checks %0d, mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial begin
		#40000;
		bad_count++;
		test_done;
	end
	initial begin
		step(4);
		`CHK("any in reset", 1'b0, o_fault_any)
		i_rst_n = 1;
		step(4);
		foreach (rows[k]) begin
			{i_drive_temperature_reading, i_detected_enc_type, ex} = rows[k];
			step(1);
			`CHK("code", ex, o_fault_code)
			{i_drive_temperature_reading, i_detected_enc_type} = 0;
			clr;
		end
		{i_nvm_rd_valid, i_nvm_rd_err} = 2'b11;
		step(1);
		{i_nvm_rd_valid, i_nvm_rd_err} = 0;
		`CHK("nvm", 8'h6A, o_fault_code)
		clr;
		i_enc_unstable = 1;
		step(1);
		i_enc_unstable = 0;
		`CHK("unstable", 8'h69, o_fault_code)
		clr;
		{i_fault_mask_param, i_hall_phase} = {16'h0004, 16'h0400};
		step(2);
		`CHK("phase masked", 1'b0, o_fault_flags[2])
		i_fault_mask_param = 0;
		step(1);
		`CHK("phase", 8'h6B, o_fault_code)
		i_hall_phase = 0;
		clr;
		i_fault_mask_param = 16'h0008;
		cur(16'h0100);
		cur(16'h0080);
		`CHK("curr masked", 1'b0, o_fault_flags[4])
		i_fault_mask_param = 0;
		cur(16'h0100);
		`CHK("curr", 8'h6D, o_fault_code)
		clr;
		i_wind_learn = 1;
		cur(16'h00F0);
		i_wind_learn = 0;
		`CHK("winding", 8'h6F, o_fault_code)
		clr;
		{i_wind_learn, i_cur_expect_up} = 2'b11;
		cur(16'h0110);
		`CHK("winding up", 1'b0, o_fault_flags[5])
		i_cur_expect_up = 0;
		cur(16'h0120);
		{i_wind_learn, i_cur_expect_up} = 2'b01;
		`CHK("winding down", 8'h6F, o_fault_code)
		clr;
		{i_host_wr, i_host_wr_data} = {1'b1, 16'h1234};
		step(1);
		{i_host_wr, i_host_rb, i_host_rb_data} = {2'b01, 16'h1234};
		step(1);
		i_host_rb_data = 16'h5555;
		step(1);
		i_host_rb = 0;
		step(1);
		`CHK("comm match", 1'b0, o_fault_flags[3])
		{i_host_wr, i_host_wr_data} = {1'b1, 16'h1234};
		step(1);
		{i_host_wr, i_host_rb, i_host_rb_data} = {2'b01, 16'h1235};
		step(1);
		i_host_rb = 0;
		step(1);
		`CHK("comm", 8'h6C, o_fault_code)
		clr;
		run = 0;
		step(3);
		i_enc_learn = 1;
		step(8);
		i_enc_learn_done = 1;
		step(1);
		{run, i_enc_learn, i_enc_learn_done} = 3'b100;
		step(1);
		`CHK("no index", 8'h71, o_fault_code)
		clr;
		{bad, i_enc_learn, i_enc_pos} = {2'b11, 24'hFFFFFF};
		step(70);
		{i_enc_learn, i_power_up_check, i_reduced_wire} = 3'b011;
		step(4);
		`CHK("hall group", 4'b1011, o_fault_flags[10:7])
		{bad, i_power_up_check, i_reduced_wire, i_enc_pos} = 0;
		step(4);
		clr;
		run = 0;
		step(1300);
		`CHK("silent", 8'h69, o_fault_code)
		run = 1;
		step(8);
		clr;
		i_drive_temperature_reading = 12'hFFF;
		step(1);
		`CHK("hot before reset", 8'h75, o_fault_code)
		{i_drive_temperature_reading, i_rst_n} = 0;
		step(1);
		`CHK("flags in reset", 12'h000, o_fault_flags)
		i_rst_n = 1;
		step(2);
		clr;
		test_done;
	end
endmodule // tb
bind sfm_monitor sfm_checker chk_u (.*);
`default_nettype wire
